// [include/tsf_pkg.sv]
`default_nettype none
package tsf_pkg;

  // command bytes of the registers held here
  localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
  localparam logic [7:0] CMD_FILTER_SELECT = 8'h06;
  localparam logic [7:0] CMD_DIODE_FAULT = 8'h07;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // filter selection layout and codes
  localparam logic [3:0] FILTER_SELECT_RST = 4'hF;
  localparam int FILT_W = 2;
  localparam int R1_FILT_LSB = 0;
  localparam int R2_FILT_LSB = 2;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_BASIC = 2'h1;
  localparam logic [1:0] FILT_RSVD = 2'h2;
  localparam logic [1:0] FILT_ENH = 2'h3;

  // common status bit positions
  localparam int CS_BUSY = 7;
  localparam int CS_INIT = 6;
  localparam int CS_LIM_C = 3;
  localparam int CS_LIM_B = 2;
  localparam int CS_LIM_A = 1;
  localparam int CS_FAULT = 0;

  // diode fault bit positions
  localparam int DF_R2_OPEN = 3;
  localparam int DF_R2_SHORT = 2;
  localparam int DF_R1_OPEN = 1;
  localparam int DF_R1_SHORT = 0;
  localparam logic [3:0] DIODE_FAULT_RST = 4'h0;

  // channels and limit sets
  localparam int N_CH = 3;
  localparam int N_LIM = 3;
  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_R1 = 2'h1;
  localparam logic [1:0] CH_R2 = 2'h2;

  // readings: 0.125 degree lsb
  localparam int RAW_W = 12;
  localparam int RD_W = 11;
  localparam int LIM_FRAC = 3;
  localparam logic [RD_W-1:0] SIGNED_MIN = 11'h400;
  localparam logic [RD_W-1:0] SIGNED_MAX = 11'h3FF;
  localparam logic [RD_W-1:0] SIGNED_FAULT = 11'h400;
  localparam logic [RD_W-1:0] UNSIGNED_FAULT = 11'h000;
  localparam logic [RD_W-1:0] UNSIGNED_MIN = 11'h000;

  // power-up not-ready time
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned INIT_TIME_MS = 30;
  localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
  localparam int INIT_CNT_W = 22;

  typedef enum logic [2:0] {
    SEQ_INIT = 3'h1,
    SEQ_IDLE = 3'h2,
    SEQ_CONV = 3'h4
  } tsf_seq_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } tsf_reg_req_t;

  typedef struct packed {
    logic [RAW_W-1:0] raw;
    logic dplus_open;
    logic dplus_short;
  } tsf_conv_res_t;

  typedef struct packed {
    logic [N_LIM-1:0][N_CH-1:0][7:0] lim;
    logic [7:0] hyst;
  } tsf_limits_t;

  typedef struct packed {
    logic [N_CH-1:0][RD_W-1:0] sval;
    logic [N_CH-1:0][RD_W-1:0] uval;
  } tsf_readings_t;

endpackage
`default_nettype wire

// [hdl/tsf_init_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tsf_init_timer #(
  parameter int unsigned INIT_CYCLES = tsf_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic pending
);
  import tsf_pkg::*;

  typedef struct packed {
    logic [INIT_CNT_W-1:0] cnt;
    logic pending;
  } tsf_init_st_t;

  localparam logic [INIT_CNT_W-1:0] LAST = INIT_CNT_W'(INIT_CYCLES - 1);
  localparam tsf_init_st_t ST_RST = '{cnt: '0, pending: 1'b1};

  tsf_init_st_t s;
  tsf_init_st_t next_s;

  // count once after reset, then hold: pending never returns
  always_comb begin
    next_s = s;
    if (s.pending) begin
      if (s.cnt == LAST) begin
        next_s.pending = 1'b0;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pending = s.pending;
endmodule
`default_nettype wire

// [hdl/tsf_hyst_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module tsf_hyst_cmp (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic update,
  input wire logic [tsf_pkg::RD_W-1:0] reading,
  input wire logic [7:0] limit,
  input wire logic [7:0] hyst,
  output logic flag
);
  import tsf_pkg::*;

  typedef struct packed {
    logic flag;
  } tsf_hyst_st_t;

  tsf_hyst_st_t s;
  tsf_hyst_st_t next_s;
  logic [RD_W-1:0] set_thr;
  logic [RD_W-1:0] clr_thr;

  // thresholds in reading units; a hysteresis above the limit floors at zero
  always_comb begin
    set_thr = {limit, {LIM_FRAC{1'b0}}};
    clr_thr = (limit >= hyst) ? {8'(limit - hyst), {LIM_FRAC{1'b0}}} : '0;
    next_s = s;
    if (update) begin
      if (reading >= set_thr) begin
        next_s.flag = 1'b1;
      end else if (reading < clr_thr) begin
        next_s.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag = s.flag;
endmodule
`default_nettype wire

// [hdl/tsf_regs.sv]
// Summary of operation
// - filter register bits 3-2 pick remote 2 filter: none, basic, enhanced.
// - filter register bits 1-0 pick remote 1 filter, same encoding.
// - unused upper bits of these three registers always read zero.
// - one-shot write during standby starts exactly one pass over enabled channels.
// - one-shot register is write-only; its data is ignored, not stored.
// - common status bit 7 reads one while a conversion runs.
// - common status bit 6 reads one during the 30 ms power-up init.
// - common status bits 3-1 are OR of limit flag sets C, B, A; bit 0 is OR of diode fault.
// - diode fault bit 3 is remote 2 open, bit 2 remote 2 short.
// - diode fault bit 1 is remote 1 open, bit 0 remote 1 short.
// - short means input at ground or minus; open means supply or floating.
// - faulted channel reads 0 unsigned and -128.000 signed.
// - standby stops periodic passes and allows one-shot; else convert at rate.
// - disabled channels are skipped in every pass, one-shot included.
// - limit flag sets at or above limit, clears below limit minus hysteresis.
`timescale 1ns/1ps
`default_nettype none
module tsf_regs #(
  parameter int unsigned INIT_CYCLES = tsf_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire tsf_pkg::tsf_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sleep_ctrl,
  input wire logic [tsf_pkg::N_CH-1:0] chan_enable,
  input wire logic rate_tick,
  input wire tsf_pkg::tsf_limits_t limits,
  output logic conv_start,
  output logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire tsf_pkg::tsf_conv_res_t conv_res,
  output logic [1:0] remote_one_filter_sel,
  output logic [1:0] remote_two_filter_sel,
  output tsf_pkg::tsf_readings_t readings,
  output logic [tsf_pkg::N_LIM-1:0][tsf_pkg::N_CH-1:0] limit_flags
);
  import tsf_pkg::*;

  typedef struct packed {
    tsf_seq_t seq;
    logic [1:0] chan;
    logic start;
    logic oneshot_pend;
    logic [3:0] filt;
    logic [3:0] diode;
    tsf_readings_t rd;
    logic [7:0] rdata;
    logic rvalid;
  } tsf_top_st_t;

  localparam tsf_top_st_t ST_RST = '{
    seq: SEQ_INIT,
    chan: CH_LOCAL,
    start: 1'b0,
    oneshot_pend: 1'b0,
    filt: FILTER_SELECT_RST,
    diode: DIODE_FAULT_RST,
    rd: '0,
    rdata: READ_ZERO,
    rvalid: 1'b0
  };

  tsf_top_st_t s;
  tsf_top_st_t next_s;
  logic init_pending;
  logic [2:0] pick;
  logic fault_now;
  logic [RD_W-1:0] cur_sval;
  logic [RD_W-1:0] cur_uval;
  logic [N_CH-1:0] cmp_upd;
  logic [7:0] common;
  logic wr_oneshot;

  // lowest enabled channel at or above 'from'; msb says one was found
  function automatic logic [2:0] pick_chan(input logic [N_CH-1:0] en,
                                           input logic [2:0] from);
    logic [2:0] r;
    r = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  tsf_init_timer #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_init (
    .clk(clk),
    .reset_n(reset_n),
    .pending(init_pending)
  );

  // reading forms for the channel now finishing; fault overrides both
  always_comb begin
    fault_now = (s.chan != CH_LOCAL) && (conv_res.dplus_open || conv_res.dplus_short);
    if (fault_now) begin
      cur_sval = SIGNED_FAULT;
      cur_uval = UNSIGNED_FAULT;
    end else begin
      if (conv_res.raw[RAW_W-1] != conv_res.raw[RAW_W-2]) begin
        cur_sval = conv_res.raw[RAW_W-1] ? SIGNED_MIN : SIGNED_MAX;
      end else begin
        cur_sval = conv_res.raw[RD_W-1:0];
      end
      cur_uval = conv_res.raw[RAW_W-1] ? UNSIGNED_MIN : conv_res.raw[RD_W-1:0];
    end
  end

  // comparators refresh only for the channel whose result just landed
  always_comb begin
    cmp_upd = '0;
    if ((s.seq == SEQ_CONV) && conv_done) begin
      cmp_upd[s.chan] = 1'b1;
    end
  end

  // one comparator per limit set and channel, all sharing one hysteresis
  for (genvar j = 0; j < N_LIM; j++) begin : g_lim
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
      tsf_hyst_cmp u_cmp (
        .clk(clk),
        .reset_n(reset_n),
        .update(cmp_upd[c]),
        .reading(cur_uval),
        .limit(limits.lim[j][c]),
        .hyst(limits.hyst),
        .flag(limit_flags[j][c])
      );
    end
  end

  // summary byte, reserved bits held at zero
  always_comb begin
    common = READ_ZERO;
    common[CS_BUSY] = (s.seq == SEQ_CONV);
    common[CS_INIT] = init_pending;
    common[CS_LIM_C] = |limit_flags[2];
    common[CS_LIM_B] = |limit_flags[1];
    common[CS_LIM_A] = |limit_flags[0];
    common[CS_FAULT] = |s.diode;
  end

  assign wr_oneshot = reg_req.wr && (reg_req.cmd == CMD_ONE_SHOT);

  // register access, trigger capture and the conversion sequencer
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.rvalid = 1'b0;
    pick = '0;

    // filter byte keeps only its four live bits
    if (reg_req.wr && (reg_req.cmd == CMD_FILTER_SELECT)) begin
      next_s.filt = reg_req.wdata[3:0];
    end

    // a pending trigger is meaningless once periodic mode resumes
    if (!sleep_ctrl) begin
      next_s.oneshot_pend = 1'b0;
    end
    // the written byte is dropped; only the write event is kept
    if (wr_oneshot && sleep_ctrl) begin
      next_s.oneshot_pend = 1'b1;
    end

    unique case (s.seq)
      SEQ_INIT: begin
        // no conversion may begin before the analog side settles
        if (!init_pending) begin
          next_s.seq = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
        if ((sleep_ctrl && s.oneshot_pend) || (!sleep_ctrl && rate_tick)) begin
          pick = pick_chan(chan_enable, 3'(CH_LOCAL));
          // a write landing now is merged into this pass
          next_s.oneshot_pend = 1'b0;
          if (pick[2]) begin
            next_s.seq = SEQ_CONV;
            next_s.chan = pick[1:0];
            next_s.start = 1'b1;
          end
        end
      end
      SEQ_CONV: begin
        if (conv_done) begin
          next_s.rd.sval[s.chan] = cur_sval;
          next_s.rd.uval[s.chan] = cur_uval;
          // fault bits track each conversion of their own channel
          if (s.chan == CH_R1) begin
            next_s.diode[DF_R1_OPEN] = conv_res.dplus_open;
            next_s.diode[DF_R1_SHORT] = conv_res.dplus_short;
          end
          if (s.chan == CH_R2) begin
            next_s.diode[DF_R2_OPEN] = conv_res.dplus_open;
            next_s.diode[DF_R2_SHORT] = conv_res.dplus_short;
          end
          pick = pick_chan(chan_enable, 3'(s.chan) + 3'h1);
          if (pick[2]) begin
            next_s.chan = pick[1:0];
            next_s.start = 1'b1;
          end else begin
            // pass over: idle until the next tick or trigger write
            next_s.seq = SEQ_IDLE;
          end
        end
      end
      default: begin
        next_s.seq = SEQ_IDLE;
      end
    endcase

    // read data lands one cycle after the read strobe
    if (reg_req.rd) begin
      next_s.rvalid = 1'b1;
      unique case (reg_req.cmd)
        CMD_COMMON_STATUS: next_s.rdata = common;
        CMD_FILTER_SELECT: next_s.rdata = {4'h0, s.filt};
        CMD_DIODE_FAULT: next_s.rdata = {4'h0, s.diode};
        default: next_s.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign conv_start = s.start;
  assign conv_chan = s.chan;
  assign readings = s.rd;
  assign remote_one_filter_sel = s.filt[R1_FILT_LSB +: FILT_W];
  assign remote_two_filter_sel = s.filt[R2_FILT_LSB +: FILT_W];
endmodule
`default_nettype wire

// [tb/tsf_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tsf_regs_chk #(
  parameter int unsigned INIT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire tsf_pkg::tsf_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sleep_ctrl,
  input wire logic [tsf_pkg::N_CH-1:0] chan_enable,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire tsf_pkg::tsf_conv_res_t conv_res,
  input wire logic [1:0] remote_one_filter_sel,
  input wire logic [1:0] remote_two_filter_sel,
  input wire tsf_pkg::tsf_readings_t readings,
  input wire logic [tsf_pkg::N_LIM-1:0][tsf_pkg::N_CH-1:0] limit_flags
);
  import tsf_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rvalid; reg_req.rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_flt2;
    reg_req.wr && reg_req.cmd == CMD_FILTER_SELECT |=>
      remote_two_filter_sel == $past(reg_req.wdata[3:2]);
  endproperty
  a_flt2: assert property (p_flt2) else $error("remote two filter wrong");
  property p_flt1;
    reg_req.wr && reg_req.cmd == CMD_FILTER_SELECT |=>
      remote_one_filter_sel == $past(reg_req.wdata[1:0]);
  endproperty
  a_flt1: assert property (p_flt1) else $error("remote one filter wrong");
  property p_shot_rd;
    reg_req.rd && reg_req.cmd == CMD_ONE_SHOT |=> reg_rdata == READ_ZERO;
  endproperty
  a_shot_rd: assert property (p_shot_rd) else $error("trigger data kept");
  property p_shot;
    reg_req.wr && reg_req.cmd == CMD_ONE_SHOT && sleep_ctrl && |chan_enable
      |-> ##[1:200] conv_start;
  endproperty
  a_shot: assert property (p_shot) else $error("trigger started no pass");
  property p_skip; conv_start |-> $past(chan_enable) >> conv_chan & 3'h1; endproperty
  a_skip: assert property (p_skip) else $error("disabled channel converted");
  property p_fault;
    conv_done && conv_chan == CH_R1 && conv_res.dplus_short |=>
      readings.sval[1] == SIGNED_FAULT && readings.uval[1] == UNSIGNED_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("faulted reading wrong");
  property p_summary;
    reg_req.rd && reg_req.cmd == CMD_COMMON_STATUS |=> reg_rdata[5:1] ==
      {2'h0, |$past(limit_flags[2]), |$past(limit_flags[1]), |$past(limit_flags[0])};
  endproperty
  a_summary: assert property (p_summary) else $error("summary bits wrong");
endmodule
bind tsf_regs tsf_regs_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk(clk), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sleep_ctrl(sleep_ctrl), .chan_enable(chan_enable), .conv_start(conv_start),
  .conv_chan(conv_chan), .conv_done(conv_done), .conv_res(conv_res),
  .remote_one_filter_sel(remote_one_filter_sel), .remote_two_filter_sel(remote_two_filter_sel),
  .readings(readings), .limit_flags(limit_flags));
`default_nettype wire

// [tb/tsf_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tsf_conv_model #(
  parameter int DLY = 4
) (
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic [tsf_pkg::RAW_W-1:0] raw,
  input wire logic [2:0] open_f,
  input wire logic [2:0] short_f,
  output tsf_pkg::tsf_conv_res_t conv_res,
  output logic conv_done
);
  import tsf_pkg::*;
  int cnt = 0;
  initial conv_res = '0;
  initial conv_done = 1'b0;
  // result after DLY cycles; between results the bus toggles so stale data is never usable
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_res <= ~conv_res;
    if (conv_start) begin
      cnt <= DLY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (cnt == 1 && !conv_start) begin
      conv_done <= 1'b1;
      conv_res <= {raw, open_f[conv_chan], short_f[conv_chan]};
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsf_pkg::*;
  logic clk, reset_n = 1'b0, sleep_ctrl = 1'b0, rate_tick = 1'b0;
  logic [2:0] chan_enable = 3'h7, open_f = 3'h0, short_f = 3'h0;
  tsf_reg_req_t req = '0;
  tsf_limits_t limits = '1;
  tsf_conv_res_t conv_res;
  tsf_readings_t readings;
  logic [7:0] reg_rdata;
  logic reg_rvalid, conv_start, conv_done;
  logic [1:0] conv_chan, f1, f2;
  logic [N_LIM-1:0][N_CH-1:0] limit_flags;
  int bad_count = 0, num_checks = 0, n_start = 0;

  tsf_regs #(.INIT_CYCLES(20)) dut (.clk(clk), .reset_n(reset_n), .reg_req(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sleep_ctrl(sleep_ctrl),
    .chan_enable(chan_enable), .rate_tick(rate_tick), .limits(limits),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_res(conv_res), .remote_one_filter_sel(f1), .remote_two_filter_sel(f2),
    .readings(readings), .limit_flags(limit_flags));
  tsf_conv_model u_conv (.clk(clk), .conv_start(conv_start), .conv_chan(conv_chan),
    .raw(12'h0C8), .open_f(open_f), .short_f(short_f), .conv_res(conv_res),
    .conv_done(conv_done));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // conversions started, one per channel, counted on the sampling edge
  always @(posedge clk) if (conv_start === 1'b1) n_start++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // extra idle cycle so back-to-back reads never touch rd twice in one step
  task automatic rd(input logic [7:0] c, output logic [8:0] x);
    req.rd = 1'b1;
    req.cmd = c;
    @(negedge clk);
    req.rd = 1'b0;
    x = {reg_rvalid, reg_rdata};
    @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    logic [8:0] x;
    rd(c, x);
    chk(x & {1'b1, m}, {1'b1, e});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    req.wr = 1'b1;
    req.cmd = c;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic t_reset;
    rdc(CMD_FILTER_SELECT, 8'h0F, 8'hFF);
    rdc(CMD_DIODE_FAULT, 8'h00, 8'hFF);
    rdc(CMD_COMMON_STATUS, 8'h40, 8'hFF);
    repeat (25) @(negedge clk);
    rdc(CMD_COMMON_STATUS, 8'h00, 8'hFF);
  endtask
  task automatic t_filter;
    logic [1:0] k[3] = '{FILT_NONE, FILT_BASIC, FILT_ENH};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        wr(CMD_FILTER_SELECT, {4'hF, k[i], k[j]});
        rdc(CMD_FILTER_SELECT, {4'h0, k[i], k[j]}, 8'hFF);
        chk({f2, f1}, {k[i], k[j]});
      end
    end
  endtask
  task automatic t_noshot;
    n_start = 0;
    wr(CMD_ONE_SHOT, 8'h5A);
    rdc(CMD_ONE_SHOT, 8'h00, 8'hFF);
    repeat (30) @(negedge clk);
    chk(n_start, 0);
    rate_tick = 1'b1;
    @(negedge clk);
    rate_tick = 1'b0;
    repeat (40) @(negedge clk);
    chk(n_start, 3);
  endtask
  // one-shot in standby; busy is polled over the register port, bounded
  task automatic t_shot(input logic [2:0] en, op, sh, input int ns, input logic [7:0] ef);
    logic [8:0] x;
    sleep_ctrl = 1'b1;
    chan_enable = en;
    open_f = op;
    short_f = sh;
    n_start = 0;
    wr(CMD_ONE_SHOT, 8'hA5);
    for (int i = 0; i < 50 && n_start == 0; i++) @(negedge clk);
    rdc(CMD_COMMON_STATUS, 8'h80, 8'h80);
    x = 9'h080;
    for (int i = 0; i < 99 && x[7]; i++) rd(CMD_COMMON_STATUS, x);
    chk(x[7], 1'b0);
    repeat (30) @(negedge clk);
    chk(n_start, ns);
    rdc(CMD_DIODE_FAULT, ef, 8'hFF);
  endtask
  task automatic t_fault;
    t_shot(3'b111, 3'b100, 3'b010, 3, 8'h09);
    rdc(CMD_COMMON_STATUS, 8'h03, 8'hFF);
    chk(readings.sval[1], SIGNED_FAULT);
    chk(readings.uval[1], UNSIGNED_FAULT);
  endtask

  // local reading 25 degrees trips only the first limit set at 20
  initial begin
    limits.hyst = 8'h02;
    for (int c = 0; c < N_CH; c++) limits.lim[0][c] = 8'h14;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_filter();
    t_noshot();
    t_fault();
    // remote 2 is skipped now, so its open bit keeps the last verdict
    t_shot(3'b010, 3'b000, 3'b000, 1, 8'h08);
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
